// *** src/acp_fifo.sv ***
// result fifo with valid/ready on both sides, storage in acp_mem
// assumes synchronous active-high reset on the same clock
module acp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         SYS_CLK,
  input  wire logic         SYS_RST,
  input  wire logic         IN_VALID,
  output logic              IN_READY,
  input  wire logic [W-1:0] IN_DATA,
  output logic              OUT_VALID,
  input  wire logic         OUT_READY,
  output logic      [W-1:0] OUT_DATA
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          settled;
  } acp_fifo_s;

  acp_fifo_s cur;
  acp_fifo_s next_cur;
  logic      push;
  logic      pop;

  // head word is valid only once its registered read has settled
  assign IN_READY  = (cur.count != (AW+1)'(DEPTH));
  assign OUT_VALID = cur.settled;
  assign push      = IN_VALID & IN_READY;
  assign pop       = OUT_VALID & OUT_READY;

  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.wr_ptr = cur.wr_ptr + AW'(1);
    end
    if (pop) begin
      next_cur.rd_ptr = cur.rd_ptr + AW'(1);
    end
    case ({push, pop})
      2'b10:   next_cur.count = cur.count + (AW+1)'(1);
      2'b01:   next_cur.count = cur.count - (AW+1)'(1);
      default: next_cur.count = cur.count;
    endcase
    // a pop moves the read address, so the new head needs one cycle
    next_cur.settled = !pop && (cur.count != '0);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  acp_mem #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_mem (
    .SYS_CLK (SYS_CLK),
    .WE      (push),
    .WADDR   (cur.wr_ptr),
    .WDATA   (IN_DATA),
    .RADDR   (cur.rd_ptr),
    .RDATA   (OUT_DATA)
  );

endmodule

// *** src/acp_mem.sv ***
// small dual-port word memory with registered read data
// assumes one clock; a read of the word being written returns the old value
module acp_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          SYS_CLK,
  input  wire logic          WE,
  input  wire logic [AW-1:0] WADDR,
  input  wire logic [W-1:0]  WDATA,
  input  wire logic [AW-1:0] RADDR,
  output logic      [W-1:0]  RDATA
);

  logic [W-1:0] store [DEPTH];

  // array is left out of reset; the fifo only reads written words
  always_ff @(posedge SYS_CLK) begin
    if (WE) begin
      store[WADDR] <= WDATA;
    end
    RDATA <= store[RADDR];
  end

endmodule

// *** src/acp_pkg.sv ***
// shared constants, pin carriers and state codes of the conversion port
// assumes a single 40 MHz system clock; the converter clock arrives on a pin
package acp_pkg;

  localparam int          RESULT_W          = 16;
  localparam int          SAMPLE_TRIGGER_N_CYCLES       = 17;
  localparam int          ACQ_CYCLES        = 3;
  localparam int          FIFO_DEPTH        = 32;
  localparam int          SYS_PERIOD_NS     = 25;
  localparam int          START_SETUP_NS    = 40;
  localparam int          START_SETUP_CYC   = (START_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int          BUSY_RISE_NS      = 70;
  localparam int          BUSY_RISE_CYC     = BUSY_RISE_NS / SYS_PERIOD_NS;

  localparam logic [1:0]  CHAN_RESET        = 2'h0;
  localparam logic [15:0] SIGN_FLIP         = 16'h8000;
  localparam logic [15:0] SAR_FIRST_MASK    = 16'h8000;
  localparam logic [4:0]  SAR_FINISH_IDX    = 5'h10;
  localparam logic [1:0]  ACQ_RESET         = 2'h0;
  localparam logic [1:0]  ACQ_LOAD          = 2'h3;
  localparam logic [1:0]  SETUP_RESET       = 2'h0;

  localparam logic [1:0]  DIV_BY_1          = 2'h0;
  localparam logic [1:0]  DIV_BY_2          = 2'h1;
  localparam logic [1:0]  DIV_BY_4          = 2'h2;
  localparam logic [1:0]  DIV_BY_8          = 2'h3;

  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_ARMED,
    ST_CONVERT,
    ST_STALL
  } acp_state_e;

  // host-side strobes and selects plus converter clock and comparator, all active levels as on the pins
  typedef struct packed {
    logic cs_n;
    logic sample_trigger_n;
    logic rd_n;
    logic byte_sel;
    logic channel_sel_msb;
    logic channel_sel_lsb;
    logic divider_sel_1;
    logic divider_sel_0;
    logic ext_clk;
    logic comp_high;
  } acp_pins_s;

  // tri-state result lanes: value and per-lane enable
  typedef struct packed {
    logic [15:0] result_bus;
    logic [15:0] result_oe;
  } acp_bus_s;

endpackage

// *** src/acp_sample_trigger_n_port.sv ***
// control and parallel readout of a four-channel 16-bit sar converter
// assumes host pins are asynchronous to SYS_CLK and the analog side gives
// one comparator decision per trial code; results also stream to a fifo

module acp_sample_trigger_n_port #(
  parameter int RESULT_W   = acp_pkg::RESULT_W,
  parameter int FIFO_DEPTH = acp_pkg::FIFO_DEPTH
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  input  wire acp_pkg::acp_pins_s    PINS,
  output logic                       BUSY,
  output logic                       SAMPLE_HOLD,
  output logic      [1:0]            CHANNEL_SEL,
  output logic      [RESULT_W-1:0]   TRIAL_CODE,
  output logic                       ACQ_DONE,
  output acp_pkg::acp_bus_s          RESULT_BUS,
  output logic                       STREAM_VALID,
  input  wire logic                  STREAM_READY,
  output logic      [RESULT_W-1:0]   STREAM_DATA
);

  typedef struct packed {
    acp_pkg::acp_state_e state;
    acp_pkg::acp_pins_s  sync1;
    acp_pkg::acp_pins_s  sync2;
    logic                clk_prev;
    logic [3:0]          div_cnt;
    logic                armed;
    logic [1:0]          setup_cnt;
    logic [4:0]          bit_idx;
    logic [15:0]         sar;
    logic [1:0]          chan_next;
    logic [1:0]          chan_cur;
    logic                addr_taken;
    logic [15:0]         result;
    logic                result_ok;
    logic [1:0]          acq_cnt;
    logic                busy;
    acp_pkg::acp_bus_s   bus;
  } acp_core_s;

  acp_core_s cur;
  acp_core_s next_cur;

  logic        fifo_in_ready;
  logic        fifo_push;
  logic [15:0] fifo_data;

  // divide ratio of the converter clock from the two select pins
  function automatic logic [3:0] div_ratio(input logic [1:0] sel);
    case (sel)
      acp_pkg::DIV_BY_1: div_ratio = 4'h1;
      acp_pkg::DIV_BY_2: div_ratio = 4'h2;
      acp_pkg::DIV_BY_4: div_ratio = 4'h4;
      acp_pkg::DIV_BY_8: div_ratio = 4'h8;
      default:           div_ratio = 4'h1;
    endcase
  endfunction

  // the trial bit for a given decision step, msb first
  function automatic logic [15:0] sar_mask(input logic [4:0] idx);
    sar_mask = acp_pkg::SAR_FIRST_MASK >> idx[3:0];
  endfunction

  logic        ext_rise;
  logic        tick;
  logic        start_req;
  logic        start_go;
  logic        rd_active;
  logic        finish;
  logic [1:0]  div_sel;
  logic [1:0]  addr_pins;

  always_comb begin
    div_sel   = {cur.sync2.divider_sel_1, cur.sync2.divider_sel_0};
    addr_pins = {cur.sync2.channel_sel_msb, cur.sync2.channel_sel_lsb};
    ext_rise  = cur.sync2.ext_clk & ~cur.clk_prev;
    // one internal clock edge every ratio external rising edges
    tick      = ext_rise && (cur.div_cnt == div_ratio(div_sel) - 4'h1);
    // strobes are active low, so both low is their nor
    start_req = ~(cur.sync2.cs_n | cur.sync2.sample_trigger_n);
    rd_active = ~(cur.sync2.cs_n | cur.sync2.rd_n);
    // a new start is taken only once the strobes were seen released
    start_go  = (cur.state == acp_pkg::ST_SAMPLE) && start_req && cur.armed;
    // finishing waits for fifo room; busy then stays high meanwhile
    finish    = fifo_in_ready && ((cur.state == acp_pkg::ST_STALL) ||
                ((cur.state == acp_pkg::ST_CONVERT) && tick &&
                 (cur.bit_idx == acp_pkg::SAR_FINISH_IDX)));
  end

  always_comb begin
    next_cur = cur;
    fifo_push = 1'b0;
    fifo_data = cur.result;

    // two flip-flops on every host pin before any logic looks at it
    next_cur.sync1    = PINS;
    next_cur.sync2    = cur.sync1;
    next_cur.clk_prev = cur.sync2.ext_clk;

    if (ext_rise) begin
      if (tick) begin
        next_cur.div_cnt = 4'h0;
      end else begin
        next_cur.div_cnt = cur.div_cnt + 4'h1;
      end
    end
    // a ratio change can leave the count past the new ratio
    if (cur.div_cnt >= div_ratio(div_sel)) begin
      next_cur.div_cnt = 4'h0;
    end

    if (!start_req) begin
      next_cur.armed = 1'b1;
    end

    // address latch on the first release of either start strobe
    if ((cur.state != acp_pkg::ST_SAMPLE) && !cur.addr_taken && !start_req) begin
      next_cur.chan_next  = addr_pins;
      next_cur.addr_taken = 1'b1;
    end

    case (cur.state)
      acp_pkg::ST_SAMPLE: begin
        if (tick && (cur.acq_cnt != acp_pkg::ACQ_RESET)) begin
          next_cur.acq_cnt = cur.acq_cnt - 2'h1;
        end
        if (start_go) begin
          next_cur.state      = acp_pkg::ST_ARMED;
          next_cur.armed      = 1'b0;
          next_cur.busy       = 1'b1;
          next_cur.setup_cnt  = acp_pkg::SETUP_RESET;
          next_cur.addr_taken = 1'b0;
          next_cur.sar        = '0;
          next_cur.bit_idx    = '0;
        end
      end
      acp_pkg::ST_ARMED: begin
        if (cur.setup_cnt != 2'(acp_pkg::START_SETUP_CYC)) begin
          next_cur.setup_cnt = cur.setup_cnt + 2'h1;
        end
        // an edge too close to the start is skipped, the next one is used
        if (tick && (cur.setup_cnt == 2'(acp_pkg::START_SETUP_CYC))) begin
          next_cur.state = acp_pkg::ST_CONVERT;
        end
      end
      acp_pkg::ST_CONVERT: begin
        if (tick && (cur.bit_idx != acp_pkg::SAR_FINISH_IDX)) begin
          if (cur.sync2.comp_high) begin
            next_cur.sar = cur.sar | sar_mask(cur.bit_idx);
          end
          next_cur.bit_idx = cur.bit_idx + 5'h1;
        end else if (tick) begin
          next_cur.state = acp_pkg::ST_STALL;
        end
      end
      acp_pkg::ST_STALL: begin
        next_cur.state = acp_pkg::ST_STALL;
      end
      default: begin
        next_cur.state = acp_pkg::ST_SAMPLE;
      end
    endcase

    if (finish) begin
      // offset-binary sar word turned into two's complement
      next_cur.result    = cur.sar ^ acp_pkg::SIGN_FLIP;
      next_cur.result_ok = 1'b1;
      next_cur.busy      = 1'b0;
      next_cur.state     = acp_pkg::ST_SAMPLE;
      next_cur.chan_cur  = cur.chan_next;
      next_cur.acq_cnt   = acp_pkg::ACQ_LOAD;
      fifo_push          = 1'b1;
      fifo_data          = cur.sar ^ acp_pkg::SIGN_FLIP;
    end

    // lanes float while busy from the cycle after busy rises; otherwise driven only during a read
    next_cur.bus.result_oe  = 16'h0000;
    next_cur.bus.result_bus = cur.bus.result_bus;
    if (!next_cur.busy && !start_go && rd_active && cur.result_ok) begin
      if (cur.sync2.byte_sel) begin
        next_cur.bus.result_bus = {8'h00, cur.result[15:8]};
        next_cur.bus.result_oe  = 16'h00ff;
      end else begin
        next_cur.bus.result_bus = cur.result;
        next_cur.bus.result_oe  = (cur.sync2.byte_sel) ? 16'h00ff : 16'hffff;
      end
    end
    if (start_go) begin
      next_cur.bus.result_oe = 16'h0000;
    end
  end

  // power-up is idle: sampling channel zero, busy low, lanes floating
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cur           <= '0;
      cur.chan_next <= acp_pkg::CHAN_RESET;
      cur.chan_cur  <= acp_pkg::CHAN_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // busy goes up from the synchronised strobes without a further flop,
  // keeping the pin-to-busy delay at two system cycles
  assign BUSY        = cur.busy | start_go;
  assign SAMPLE_HOLD = (cur.state != acp_pkg::ST_SAMPLE);
  assign CHANNEL_SEL = cur.chan_cur;
  assign TRIAL_CODE  = (cur.state == acp_pkg::ST_CONVERT) ?
                       (cur.sar | sar_mask(cur.bit_idx)) : cur.sar;
  assign ACQ_DONE    = (cur.state == acp_pkg::ST_SAMPLE) &&
                       (cur.acq_cnt == acp_pkg::ACQ_RESET);
  assign RESULT_BUS  = cur.bus;

  acp_fifo #(
    .W     (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .SYS_CLK   (SYS_CLK),
    .SYS_RST   (SYS_RST),
    .IN_VALID  (fifo_push),
    .IN_READY  (fifo_in_ready),
    .IN_DATA   (fifo_data),
    .OUT_VALID (STREAM_VALID),
    .OUT_READY (STREAM_READY),
    .OUT_DATA  (STREAM_DATA)
  );

endmodule

// *** test/acp_analog_model.sv ***
// converter clock source and comparator of the analog side
// assumes TRIAL_CODE is offset binary and steady between ticks
module acp_analog_model (
  input wire logic        SYS_CLK,
  input wire logic [1:0]  CHANNEL_SEL,
  input wire logic [15:0] TRIAL_CODE,
  input wire logic [15:0] OFFSET,
  output logic            EXT_CLK,
  output logic            COMP_HIGH
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0]  phase = 3'h0;
  logic [15:0] level;
  // each channel differs in its top two bits so a wrong mux shows
  assign level = OFFSET ^ {CHANNEL_SEL, 14'h0000};
  assign COMP_HIGH = level >= TRIAL_CODE;
  always @(posedge SYS_CLK) begin
    phase <= phase + 3'h1;
  end
  // 8 system clocks: 200 ns, the fastest legal internal rate
  assign EXT_CLK = phase[2];
endmodule

// *** test/acp_monitor.sv ***
// timing checks on the conversion port's output pins
// assumes binding to acp_sample_trigger_n_port and a converter tick no closer than 4 clocks
module acp_monitor (
  input wire logic              SYS_CLK,
  input wire logic              SYS_RST,
  input wire logic              BUSY,
  input wire logic              SAMPLE_HOLD,
  input wire logic [1:0]        CHANNEL_SEL,
  input wire acp_pkg::acp_bus_s RESULT_BUS,
  input wire logic              STREAM_VALID
);
  timeunit 1ns;
  timeprecision 100ps;
  // 17 ticks, each at least 4 system clocks apart
  localparam int MIN_BUSY = 68;
  int unsigned run;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !BUSY) begin
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_busy_len; $fell(BUSY) |-> run >= MIN_BUSY; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short");
  property p_hold_rise; $rose(BUSY) |=> SAMPLE_HOLD; endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("hold late");
  property p_hold_in_busy; SAMPLE_HOLD |-> BUSY; endproperty
  a_hold_in_busy: assert property (p_hold_in_busy) else $error("hold without busy");
  // lanes may still drive in the cycle busy rises, so only the hold span is checked
  property p_float; SAMPLE_HOLD |-> RESULT_BUS.result_oe == 16'h0000; endproperty
  a_float: assert property (p_float) else $error("lanes driven in busy");
  property p_lanes;
    RESULT_BUS.result_oe inside {16'h0000, 16'h00ff, 16'hffff};
  endproperty
  a_lanes: assert property (p_lanes) else $error("odd lane enable");
  property p_byte_hi; RESULT_BUS.result_oe == 16'h00ff |-> RESULT_BUS.result_bus[15:8] == 8'h00;
  endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("upper lanes busy");
  property p_chan; $changed(CHANNEL_SEL) |-> $fell(BUSY); endproperty
  a_chan: assert property (p_chan) else $error("channel moved mid run");
  property p_push; $fell(BUSY) |-> ##[1:3] STREAM_VALID; endproperty
  a_push: assert property (p_push) else $error("result not stored");
  property p_idle;
    $fell(SYS_RST) |-> !BUSY && RESULT_BUS.result_oe == 16'h0000 && CHANNEL_SEL == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
endmodule

bind acp_sample_trigger_n_port acp_monitor mon_u (
  .SYS_CLK(SYS_CLK),
  .SYS_RST(SYS_RST),
  .BUSY(BUSY),
  .SAMPLE_HOLD(SAMPLE_HOLD),
  .CHANNEL_SEL(CHANNEL_SEL),
  .RESULT_BUS(RESULT_BUS),
  .STREAM_VALID(STREAM_VALID)
);

// *** test/tb.sv ***
// self-checking bench of the conversion port with the analog model
// assumes the host strobes are driven 2 ns after each rising edge
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               SYS_CLK = 1'b0;
  logic               SYS_RST = 1'b1;
  logic               STREAM_READY = 1'b1;
  logic [15:0]        offset = 16'h0000;
  acp_pkg::acp_pins_s pins = 10'h380;
  acp_pkg::acp_pins_s pins_in;
  acp_pkg::acp_bus_s  rbus;
  logic               busy, hold, acq, svalid, ext, comp;
  logic [1:0]         chan;
  logic [15:0]        trial, sdata;
  int                 fails = 0;
  int                 samples_checked = 0;
  int                 ratio = 1;
  logic [15:0]        exp_q[$];

  always #12.5 SYS_CLK = ~SYS_CLK;
  always_comb begin
    pins_in = pins;
    pins_in.ext_clk = ext;
    pins_in.comp_high = comp;
  end
  acp_sample_trigger_n_port dut_u (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PINS(pins_in), .BUSY(busy),
    .SAMPLE_HOLD(hold), .CHANNEL_SEL(chan), .TRIAL_CODE(trial), .ACQ_DONE(acq),
    .RESULT_BUS(rbus), .STREAM_VALID(svalid), .STREAM_READY(STREAM_READY), .STREAM_DATA(sdata));
  acp_analog_model model_u (.SYS_CLK(SYS_CLK), .CHANNEL_SEL(chan), .TRIAL_CODE(trial),
    .OFFSET(offset), .EXT_CLK(ext), .COMP_HIGH(comp));

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [15:0] expect_of(input logic [1:0] ch);
    return offset ^ {ch, 14'h0000} ^ 16'h8000;
  endfunction
  task automatic start(input logic [1:0] nxt);
    pins.channel_sel_msb = nxt[1];
    pins.channel_sel_lsb = nxt[0];
    pins.cs_n = 1'b0;
    pins.sample_trigger_n = 1'b0;
    tick(2); // 50 ns low
    chk("busy rise", 16'h1, busy);
    // first rise latches nxt for the following run
    pins.cs_n = 1'b1;
    pins.sample_trigger_n = 1'b1;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (busy !== 1'b0) begin
      if (n >= 3000) begin
        chk("busy fall", 16'h0, busy);
        end_sim();
      end
      tick(1);
      n++;
    end
  endtask
  task automatic convert(input logic [1:0] nxt, output int n);
    start(nxt);
    wait_done(n);
    chk("acq running", 16'h0, acq);
    // three acquisition clocks plus margin, also the 600 ns gap
    tick(24 * ratio + 12);
    chk("acq done", 16'h1, acq);
  endtask
  task automatic read_chk(input logic bsel, input logic [15:0] e_oe, input logic [15:0] e_bus);
    pins.byte_sel = bsel;
    pins.cs_n = 1'b0;
    pins.rd_n = 1'b0;
    tick(4);
    chk("lane enable", e_oe, rbus.result_oe);
    chk("lane data", e_bus, rbus.result_bus);
    pins.cs_n = 1'b1;
    pins.rd_n = 1'b1;
    tick(4);
    chk("lane release", 16'h0000, rbus.result_oe);
    // 1.5 internal clocks after the read rise before any start
    tick(12 * ratio);
  endtask

  task automatic t_idle;
    chk("idle busy", 16'h0, busy);
    chk("idle lanes", 16'h0, rbus.result_oe);
    chk("idle channel", 16'h0, chan);
    chk("idle acq", 16'h1, acq);
  endtask
  task automatic t_pairing;
    int n;
    logic [15:0] e;
    offset = 16'h1234;
    convert(2'h2, n);
    chk("next channel", 16'h2, chan);
    e = expect_of(2'h0);
    read_chk(1'b0, 16'hffff, e);
    read_chk(1'b1, 16'h00ff, {8'h00, e[15:8]});
    convert(2'h1, n);
    read_chk(1'b0, 16'hffff, expect_of(2'h2));
    chk("next channel", 16'h1, chan);
    convert(2'h3, n);
    read_chk(1'b0, 16'hffff, expect_of(2'h1));
    convert(2'h0, n);
    read_chk(1'b0, 16'hffff, expect_of(2'h3));
    chk("next channel", 16'h0, chan);
  endtask
  task automatic t_divider;
    int n;
    for (int d = 0; d < 4; d++) begin
      {pins.divider_sel_1, pins.divider_sel_0} = d[1:0];
      ratio = 1 << d;
      tick(4);
      convert(2'h0, n);
      chk("busy length", 16'h1, 16'(n >= 136 * ratio && n <= 144 * ratio + 12));
    end
    {pins.divider_sel_1, pins.divider_sel_0} = 2'h0;
    ratio = 1;
  endtask
  task automatic t_read_busy;
    int n;
    pins.byte_sel = 1'b0;
    pins.cs_n = 1'b0;
    pins.rd_n = 1'b0;
    tick(4);
    chk("read before start", 16'hffff, rbus.result_oe);
    pins.sample_trigger_n = 1'b0;
    tick(2);
    pins.sample_trigger_n = 1'b1;
    tick(2);
    chk("float at start", 16'h0000, rbus.result_oe);
    pins.cs_n = 1'b1;
    pins.rd_n = 1'b1;
    wait_done(n);
    tick(36);
  endtask
  task automatic t_fifo;
    int n;
    STREAM_READY = 1'b0;
    for (int i = 0; i < 32; i++) begin
      offset = 16'(i);
      convert(2'h0, n);
      exp_q.push_back(expect_of(2'h0));
    end
    offset = 16'h0021;
    start(2'h0);
    tick(600);
    chk("stall when full", 16'h1, busy);
    exp_q.push_back(expect_of(2'h0));
    STREAM_READY = 1'b1;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      if (svalid === 1'b1) begin
        chk("stream word", exp_q.pop_front(), sdata);
      end
      tick(1);
      n++;
    end
    chk("stream left", 16'h0, 16'(exp_q.size()));
    tick(36);
  endtask

  initial begin
    tick(5);
    SYS_RST = 1'b0;
    tick(4);
    t_idle();
    t_pairing();
    t_divider();
    t_read_busy();
    t_fifo();
    SYS_RST = 1'b1;
    tick(3);
    t_idle();
    SYS_RST = 1'b0;
    tick(4);
    t_idle();
    // no result since reset, so a read must leave the lanes floating
    read_chk(1'b0, 16'h0000, 16'h0000);
    end_sim();
  end
endmodule
